// file: rtl/dfc_pkg.sv
/*
  Shared constants for the decimation filter control port: timing,
  status and configuration field positions, reset values.
  Assumes a single 100 MHz clock domain.
*/
package dfc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MOD_CLK_HZ = 1_024_000;
  localparam int BIT_RATE_HZ = 256_000;
  // Half period of the modulator clock, rounded down
  localparam int MOD_HALF_CYC = CLK_HZ / (2 * MOD_CLK_HZ);
  // Modulator clocks per bitstream bit (1.024 MHz / 256 kHz)
  localparam int CLK_PER_BIT = MOD_CLK_HZ / BIT_RATE_HZ;
  localparam int DATA_W = 24;
  localparam int STAT_W = 16;
  localparam int CFG_W = 8;
  localparam int CAL_WORD = 57;
  localparam int ACC_W = 32;
  localparam int BASE_CLOCKS = 16384;
  // Status bit positions, MSB first on the wire
  localparam int ST_ERR = 15;
  localparam int ST_OVW = 14;
  localparam int ST_MODULATOR_UNSTABLE_FLAG = 13;
  localparam int ST_ACCUM1_FAULT = 12;
  localparam int ST_ACCUM2_FAULT = 11;
  localparam int ST_RDY = 10;
  localparam int ST_SYNC1 = 9;
  localparam int ST_CALD = 8;
  // Configuration byte positions
  localparam int CF_PWD = 7;
  localparam int CF_CAL = 6;
  localparam int CF_OFS = 5;
  localparam int CF_SRC = 4;
  localparam int CF_RSV = 3;
  localparam int CF_DECIM_SEL2 = 2;
  localparam int CF_DECIM_SEL1 = 1;
  localparam int CF_DECIM_SEL0 = 0;
  localparam logic [2:0] DEC_RESERVED = 3'h7;
  localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;
  localparam logic [7:0] CFG_RST = 8'h00;
  typedef enum logic [1:0] {FS_IDLE = 2'b00, FS_WAIT = 2'b01, FS_RUN = 2'b11} fstate_e;
endpackage

// file: rtl/pin_sync.sv
/*
  Two-flop synchroniser bank for asynchronous pins.
  Assumes inputs are quasi-static relative to clk or sampled by a slower rate.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic rst, // unused: pins stay visible in reset
  input wire logic [W-1:0] d, // async inputs
  output logic [W-1:0] q // synchronised
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // First stage feeds only the second
  always_comb
  begin
    nxt_meta = d;
    nxt_q = meta_ff;
  end

  // Runs through reset, so reset can load the configuration from the pins
  always_ff @(posedge clk)
  begin
    meta_ff <= nxt_meta;
    q_ff <= nxt_q;
  end

  assign q = q_ff;
endmodule

// file: rtl/serial_port.sv
/*
  Host serial port: shifts status or data out on rising sclk,
  captures config writes on falling sclk. Edges arrive as one-cycle pulses
  from already synchronised pins.
*/
`timescale 1ns/100ps
module serial_port
  import dfc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic sel_n, // chip select, low active, synced
  input wire logic rd_wr, // high read, low write, synced
  input wire logic sclk_rise, // sclk rising pulse
  input wire logic sclk_fall, // sclk falling pulse
  input wire logic sin, // serial in, synced
  input wire logic choose_data, // high data, low status
  input wire logic [DATA_W-1:0] data_word, // held conversion word
  input wire logic [STAT_W-1:0] stat_word, // live status word
  output logic sout, // serial out bit
  output logic sout_oe, // serial out drive enable
  output logic data_touch, // first data bit read pulse
  output logic data_done, // data lsb read pulse
  output logic stat_done, // status read finished pulse
  output logic cfg_wr, // config write pulse
  output logic [CFG_W-1:0] cfg_data // written config byte
);
  logic [DATA_W-1:0] sh_ff, nxt_sh;
  logic [4:0] cnt_ff, nxt_cnt;
  logic is_data_ff, nxt_is_data;
  logic sout_ff, nxt_sout;
  logic [CFG_W-1:0] wr_ff, nxt_wr;
  logic [3:0] wcnt_ff, nxt_wcnt;
  logic [CFG_W-1:0] cfg_ff, nxt_cfg;
  logic act;
  logic wr_done_ff, nxt_wr_done;

  assign act = !sel_n;

  // Shift engine; deselect restarts both directions
  always_comb
  begin
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_is_data = is_data_ff;
    nxt_sout = sout_ff;
    nxt_wr = wr_ff;
    nxt_wcnt = wcnt_ff;
    nxt_cfg = cfg_ff;
    data_touch = 1'b0;
    data_done = 1'b0;
    stat_done = 1'b0;
    nxt_wr_done = 1'b0;
    if (!act)
    begin // [RULE15]
      nxt_cnt = 5'h00;
      nxt_wcnt = 4'h0;
    end
    else if (rd_wr)
    begin
      if (sclk_rise)
      begin // [RULE16] [RULE7]
        if (cnt_ff == 5'h00)
        begin
          nxt_is_data = choose_data; // [RULE20]
          nxt_sh = choose_data ? data_word : {stat_word, 8'h00};
          nxt_sout = choose_data ? data_word[DATA_W-1] : stat_word[STAT_W-1];
          nxt_cnt = 5'h01;
        end
        else
        begin
          nxt_sh = {sh_ff[DATA_W-2:0], 1'b0};
          nxt_sout = sh_ff[DATA_W-2];
          nxt_cnt = cnt_ff + 5'h01;
        end
      end
      if (sclk_fall && cnt_ff != 5'h00)
      begin
        if (is_data_ff && cnt_ff == 5'h01)
          data_touch = 1'b1;
        if (is_data_ff && cnt_ff == 5'(DATA_W)) // [RULE25]
          data_done = 1'b1;
        if (!is_data_ff && cnt_ff == 5'(STAT_W)) // [RULE24]
          stat_done = 1'b1;
      end
    end
    else if (sclk_fall)
    begin // [RULE16] [RULE19]
      nxt_wr = {wr_ff[CFG_W-2:0], sin};
      if (wcnt_ff == 4'(CFG_W - 1))
      begin
        nxt_cfg = {wr_ff[CFG_W-2:0], sin};
        nxt_wr_done = 1'b1;
        nxt_wcnt = 4'h0;
      end
      else
        nxt_wcnt = wcnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sh_ff <= DATA_RST;
      cnt_ff <= 5'h00;
      is_data_ff <= 1'b0;
      sout_ff <= 1'b0;
      wr_ff <= CFG_RST;
      wcnt_ff <= 4'h0;
      cfg_ff <= CFG_RST;
      wr_done_ff <= 1'b0;
    end
    else
    begin
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      is_data_ff <= nxt_is_data;
      sout_ff <= nxt_sout;
      wr_ff <= nxt_wr;
      wcnt_ff <= nxt_wcnt;
      cfg_ff <= nxt_cfg;
      wr_done_ff <= nxt_wr_done;
    end
  end

  assign sout = sout_ff;
  assign sout_oe = act && rd_wr; // [RULE17]
  assign cfg_data = cfg_ff;
  // Strobe one cycle late, once the new byte is already held
  assign cfg_wr = wr_done_ff;
endmodule

// file: rtl/decimation_filter_control_port.sv
/*
  Control and serial port of the decimation filter chip. Drives the
  modulator clock and resync, takes the modulator bitstream and flag,
  runs a simple sinc-style accumulate-and-dump decimator, and serves a
  host serial port. Assumes all pins other than clk and rst are asynchronous.
*/
`timescale 1ns/100ps
// Behaviour
// RULE1: Drive modulator clock near 1.024 MHz divided from the filter clock.
// RULE2: Raise modulator resync low to high to realign the modulator.
// RULE3: Take one bitstream bit per 256 kHz sample period.
// RULE4: Modulator flag rising sets an error status bit.
// RULE5: Error output pulled low, open-drain, when any error bit set.
// RULE6: Word-waiting high while a conversion word awaits reading.
// RULE7: Serial out two's complement, MSB first, changing on rising sclk.
// RULE8: Source select high takes test bitstream, low modulator bitstream.
// RULE9: Reset clears state, zeroes errors, data, offset; config from pins.
// RULE10: After reset, convolutions wait for a frame sync pulse.
// RULE11: Convolution starts with frame sync; period-aligned syncs are harmless.
// RULE12: Power-down stops convolution and modulator clock, keeps registers, port.
// RULE13: After power-down, convolutions wait for frame sync.
// RULE14: Mode select high uses pins, low uses last configuration write.
// RULE15: Chip select high ignores serial in, read/write and sclk.
// RULE16: Writes capture on falling sclk; reads drive on rising sclk.
// RULE17: Serial out floats while read/write is low.
// RULE18: Host makes sclk and holds serial in valid at falling edges.
// RULE19: Written words MSB first, latched on falling sclk.
// RULE20: Register choose high reads data word, low reads status word.
// RULE21: Offset correction high subtracts stored offset, low leaves words raw.
// RULE22: Sync after calibration request rise calibrates; offset is 57th word.
// RULE23: Decimation code sets 16384 clocks down to 256; code 111 reserved.
// RULE24: Status word is 16 bits of error, ready, sync, cal, config flags.
// RULE25: Each conversion word reads out as 24 bits per output period.
module decimation_filter_control_port
  import dfc_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic rst, // sync reset, high
  output logic mod_clk, // modulator clock out
  output logic modulator_resync, // modulator resync out
  input wire logic modulator_bitstream, // modulator bitstream pin
  input wire logic test_bitstream, // test bitstream pin
  input wire logic modulator_unstable_flag, // modulator flag pin
  input wire logic frame_sync, // frame sync pin
  input wire logic power_down, // power-down pin
  input wire logic source_select, // source select pin
  input wire logic hw_mode, // high pins control, low config
  input wire logic decim_sel0, // decimation select bit 0
  input wire logic decim_sel1, // decimation select bit 1
  input wire logic decim_sel2, // decimation select bit 2
  input wire logic apply_offset_correction, // offset correction pin
  input wire logic offset_cal_request, // calibration request pin
  input wire logic accum1_fault, // first accumulator fault in
  input wire logic accum2_fault, // second accumulator fault in
  input wire logic chip_sel_n, // chip select, low active
  input wire logic read_write, // high read, low write
  input wire logic sclk, // host serial clock
  input wire logic serial_in, // host serial data in
  input wire logic register_choose, // high data, low status
  output logic serial_out, // serial data out
  output logic serial_out_oe, // serial out drive enable
  output logic error_n_out, // error pin level, always low
  output logic error_n_oe, // error pin pull-down enable
  output logic word_waiting // conversion word ready
);
  import dfc_pkg::*;

  localparam int NP = 19;
  logic [NP-1:0] pin_raw, pin_s;
  logic s_mbit, s_tbit, s_modulator_unstable_flag, s_sync, s_pwd, s_src, s_dec0, s_dec1, s_dec2;
  logic s_ofs, s_cal, s_a1, s_a2, s_csn, s_rw, s_sclk, s_sin, s_register_choose, s_hw;

  // Every asynchronous pin passes two flops first
  assign pin_raw = {modulator_bitstream, test_bitstream, modulator_unstable_flag,
    frame_sync, power_down, source_select, decim_sel0, decim_sel1, decim_sel2,
    apply_offset_correction, offset_cal_request, accum1_fault, accum2_fault,
    chip_sel_n, read_write, sclk, serial_in, register_choose, hw_mode};
  assign {s_mbit, s_tbit, s_modulator_unstable_flag, s_sync, s_pwd, s_src, s_dec0, s_dec1, s_dec2,
    s_ofs, s_cal, s_a1, s_a2, s_csn, s_rw, s_sclk, s_sin, s_register_choose, s_hw} = pin_s;

  pin_sync #(.W(NP)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pin_raw),
    .q(pin_s)
  );

  // Clocks per output word for a decimation code; reserved code held at slowest
  function automatic logic [14:0] clocks_per_word(input logic [2:0] code);
    if (code == DEC_RESERVED)
      clocks_per_word = 15'(BASE_CLOCKS - 1);
    else
      clocks_per_word = 15'((BASE_CLOCKS >> code) - 1); // [RULE23]
  endfunction

  // State registers
  logic sclk_q_ff, nxt_sclk_q, sync_q_ff, nxt_sync_q, modulator_unstable_flag_q_ff, nxt_modulator_unstable_flag_q;
  logic cal_q_ff, nxt_cal_q;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [5:0] mdiv_ff, nxt_mdiv;
  logic mclk_ff, nxt_mclk;
  logic [1:0] bdiv_ff, nxt_bdiv;
  logic resync_ff, nxt_resync;
  fstate_e fs_ff, nxt_fs;
  logic [14:0] wcnt_ff, nxt_wcnt;
  logic signed [ACC_W-1:0] acc_ff, nxt_acc;
  logic [DATA_W-1:0] data_ff, nxt_data, ofs_ff, nxt_ofs;
  logic rdy_ff, nxt_rdy, pend_rd_ff, nxt_pend_rd;
  logic ovw_ff, nxt_ovw, mfe_ff, nxt_mfe, a1_ff, nxt_a1, a2_ff, nxt_a2;
  logic [1:0] after_sync_ff, nxt_after_sync;
  logic sync1_ff, nxt_sync1, cald_ff, nxt_cald;
  logic cal_arm_ff, nxt_cal_arm, cal_run_ff, nxt_cal_run;
  logic [5:0] calw_ff, nxt_calw;

  logic sclk_rise, sclk_fall, sync_rise, modulator_unstable_flag_rise, cal_rise;
  logic [7:0] eff_cfg, pin_cfg;
  logic data_touch, data_done, stat_done, cfg_wr;
  logic [CFG_W-1:0] cfg_data;
  logic [STAT_W-1:0] stat_word;
  logic any_err, bit_in, bit_tick, word_end;
  logic [DATA_W-1:0] raw_word, corr_word;

  assign sclk_rise = s_sclk && !sclk_q_ff;
  assign sclk_fall = !s_sclk && sclk_q_ff;
  assign sync_rise = s_sync && !sync_q_ff;
  assign modulator_unstable_flag_rise = s_modulator_unstable_flag && !modulator_unstable_flag_q_ff;
  assign cal_rise = s_cal && !cal_q_ff;

  // Pin view of the configuration byte; reserved bit reads zero
  assign pin_cfg = {s_pwd, s_cal, s_ofs, s_src, 1'b0, s_dec2, s_dec1, s_dec0};
  assign eff_cfg = s_hw ? pin_cfg : cfg_ff; // [RULE14]
  assign bit_in = eff_cfg[CF_SRC] ? s_tbit : s_mbit; // [RULE8]
  assign any_err = ovw_ff || mfe_ff || a1_ff || a2_ff;
  assign bit_tick = (bdiv_ff == 2'(CLK_PER_BIT - 1)) && mdiv_ff == 6'h00 && !mclk_ff;
  assign word_end = bit_tick && fs_ff == FS_RUN && wcnt_ff == 15'h0000;
  assign raw_word = acc_ff[ACC_W-1 -: DATA_W];
  // During calibration the offset register is bypassed
  assign corr_word = (eff_cfg[CF_OFS] && !cal_run_ff) ? raw_word - ofs_ff : raw_word; // [RULE21]

  assign stat_word = {any_err, ovw_ff, mfe_ff, a1_ff, a2_ff, rdy_ff, sync1_ff, cald_ff,
    eff_cfg[CF_PWD], eff_cfg[CF_CAL], eff_cfg[CF_OFS] && !cal_run_ff, eff_cfg[CF_SRC],
    1'b0, eff_cfg[CF_DECIM_SEL2], eff_cfg[CF_DECIM_SEL1], eff_cfg[CF_DECIM_SEL0]}; // [RULE24]

  serial_port u_port (
    .clk(clk),
    .rst(rst),
    .sel_n(s_csn),
    .rd_wr(s_rw),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .sin(s_sin),
    .choose_data(s_register_choose),
    .data_word(data_ff),
    .stat_word(stat_word),
    .sout(serial_out),
    .sout_oe(serial_out_oe),
    .data_touch(data_touch),
    .data_done(data_done),
    .stat_done(stat_done),
    .cfg_wr(cfg_wr),
    .cfg_data(cfg_data)
  );

  // Clocking, framing, decimation and status next-state
  always_comb
  begin
    nxt_sclk_q = s_sclk;
    nxt_sync_q = s_sync;
    nxt_modulator_unstable_flag_q = s_modulator_unstable_flag;
    nxt_cal_q = s_cal;
    nxt_cfg = cfg_wr ? cfg_data : cfg_ff;
    nxt_mdiv = mdiv_ff;
    nxt_mclk = mclk_ff;
    nxt_bdiv = bdiv_ff;
    nxt_resync = resync_ff;
    nxt_fs = fs_ff;
    nxt_wcnt = wcnt_ff;
    nxt_acc = acc_ff;
    nxt_data = data_ff;
    nxt_ofs = ofs_ff;
    nxt_rdy = rdy_ff;
    nxt_pend_rd = pend_rd_ff;
    nxt_ovw = ovw_ff;
    nxt_mfe = mfe_ff;
    nxt_a1 = a1_ff;
    nxt_a2 = a2_ff;
    nxt_after_sync = after_sync_ff;
    nxt_sync1 = sync1_ff;
    nxt_cald = cald_ff;
    nxt_cal_arm = cal_arm_ff || cal_rise;
    nxt_cal_run = cal_run_ff;
    nxt_calw = calw_ff;
    // Modulator clock divider; halted in power-down
    if (!eff_cfg[CF_PWD])
    begin // [RULE1] [RULE12]
      if (mdiv_ff == 6'(MOD_HALF_CYC - 1))
      begin
        nxt_mdiv = 6'h00;
        nxt_mclk = !mclk_ff;
        if (mclk_ff)
          nxt_bdiv = bdiv_ff + 2'h1; // [RULE3]
      end
      else
        nxt_mdiv = mdiv_ff + 6'h01;
    end
    // Framing: power-down drops back to waiting for sync
    case (fs_ff)
      FS_IDLE:
      begin
        nxt_fs = FS_WAIT; // [RULE10]
      end
      FS_WAIT:
      begin
        nxt_resync = 1'b0;
        if (sync_rise && !eff_cfg[CF_PWD])
        begin // [RULE11] [RULE13]
          nxt_fs = FS_RUN;
          nxt_resync = 1'b1; // [RULE2]
          nxt_bdiv = 2'h0;
          nxt_wcnt = clocks_per_word(eff_cfg[2:0]) >> 2;
          nxt_acc = '0;
          nxt_after_sync = 2'h0;
        end
      end
      FS_RUN:
      begin
        if (eff_cfg[CF_PWD])
          nxt_fs = FS_WAIT; // [RULE12]
        else if (sync_rise && wcnt_ff != 15'h0000)
        begin // Off-period sync restarts the frame
          nxt_wcnt = clocks_per_word(eff_cfg[2:0]) >> 2;
          nxt_acc = '0;
          nxt_resync = 1'b1;
          nxt_after_sync = 2'h0;
        end
        else if (bit_tick)
        begin
          nxt_resync = 1'b0;
          nxt_acc = acc_ff + (bit_in ? 32'sh00010000 : -32'sh00010000);
          nxt_wcnt = wcnt_ff - 15'h0001;
          if (word_end)
          begin
            nxt_acc = '0;
            nxt_wcnt = clocks_per_word(eff_cfg[2:0]) >> 2;
          end
        end
      end
      default:
        nxt_fs = FS_IDLE;
    endcase
    if (sync_rise && cal_arm_ff)
    begin // [RULE22]
      nxt_cal_arm = cal_rise;
      nxt_cal_run = 1'b1;
      nxt_calw = 6'h00;
    end
    // Word completion: load, or flag overwrite when a read is under way
    if (word_end)
    begin
      nxt_sync1 = after_sync_ff == 2'h1;
      if (after_sync_ff != 2'h3)
        nxt_after_sync = after_sync_ff + 2'h1;
      nxt_cald = 1'b0;
      if (cal_run_ff)
        nxt_calw = calw_ff + 6'h01;
      if (cal_run_ff && calw_ff == 6'(CAL_WORD - 1))
      begin
        nxt_ofs = raw_word;
        nxt_cald = 1'b1;
        nxt_cal_run = 1'b0;
      end
      if (pend_rd_ff)
        nxt_ovw = 1'b1;
      else
      begin
        nxt_data = corr_word;
        nxt_rdy = 1'b1; // [RULE6]
      end
    end
    if (data_touch)
      nxt_pend_rd = 1'b1;
    if (data_done)
    begin
      nxt_pend_rd = 1'b0;
      nxt_rdy = 1'b0;
    end
    // Status read clears errors; a new event that cycle wins
    if (stat_done)
    begin
      nxt_ovw = 1'b0;
      nxt_mfe = s_modulator_unstable_flag;
      nxt_a1 = s_a1;
      nxt_a2 = s_a2;
    end
    if (modulator_unstable_flag_rise)
      nxt_mfe = 1'b1; // [RULE4]
    if (s_a1)
      nxt_a1 = 1'b1;
    if (s_a2)
      nxt_a2 = 1'b1;
    if (word_end && pend_rd_ff)
      nxt_ovw = 1'b1;
  end

  // Registers; config loads from pins at reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin // [RULE9]
      {sclk_q_ff, sync_q_ff, modulator_unstable_flag_q_ff, cal_q_ff, mclk_ff, resync_ff} <= '0;
      {mdiv_ff, bdiv_ff, wcnt_ff, acc_ff, rdy_ff, pend_rd_ff} <= '0;
      {ovw_ff, mfe_ff, a1_ff, a2_ff, sync1_ff, cald_ff} <= '0;
      {cal_arm_ff, cal_run_ff, calw_ff} <= '0;
      cfg_ff <= pin_cfg;
      fs_ff <= FS_IDLE;
      data_ff <= DATA_RST;
      ofs_ff <= DATA_RST;
      after_sync_ff <= 2'h3;
    end
    else
    begin
      {sclk_q_ff, sync_q_ff, modulator_unstable_flag_q_ff} <= {nxt_sclk_q, nxt_sync_q, nxt_modulator_unstable_flag_q};
      {cal_q_ff, cfg_ff, mdiv_ff, mclk_ff} <= {nxt_cal_q, nxt_cfg, nxt_mdiv, nxt_mclk};
      {bdiv_ff, resync_ff, wcnt_ff, acc_ff} <= {nxt_bdiv, nxt_resync, nxt_wcnt, nxt_acc};
      fs_ff <= nxt_fs;
      {data_ff, ofs_ff, rdy_ff, pend_rd_ff} <= {nxt_data, nxt_ofs, nxt_rdy, nxt_pend_rd};
      {ovw_ff, mfe_ff, a1_ff, a2_ff, sync1_ff} <= {nxt_ovw, nxt_mfe, nxt_a1, nxt_a2, nxt_sync1};
      {after_sync_ff, cald_ff, cal_arm_ff} <= {nxt_after_sync, nxt_cald, nxt_cal_arm};
      {cal_run_ff, calw_ff} <= {nxt_cal_run, nxt_calw};
    end
  end

  assign mod_clk = mclk_ff;
  assign modulator_resync = resync_ff;
  assign word_waiting = rdy_ff;
  assign error_n_out = 1'b0;
  assign error_n_oe = any_err; // [RULE5]
endmodule

// file: testbench/decimation_filter_control_port_assertions.sv
/*
  Pin-level checker for the filter control port.
  Assumes a bind onto the top module and the single clk domain.
*/
`timescale 1ns/100ps
module dfc_checker (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic mod_clk, // modulator clock
  input wire logic modulator_resync, // resync out
  input wire logic modulator_unstable_flag, // flag pin
  input wire logic frame_sync, // sync pin
  input wire logic power_down, // power-down pin
  input wire logic chip_sel_n, // chip select
  input wire logic read_write, // read/write
  input wire logic sclk, // serial clock
  input wire logic serial_out, // serial out
  input wire logic serial_out_oe, // serial out enable
  input wire logic error_n_out, // error level
  input wire logic error_n_oe // error enable
);
  logic [1:0] up_ff;
  logic [5:0] mc_ff;
  logic [9:0] fs_ff;
  logic [3:0] sr_ff;
  logic mq_ff, sk_ff, seen_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Ages; the clock check waits for one clean edge since reset or stop
  always_ff @(posedge clk)
  begin
    mq_ff <= mod_clk;
    sk_ff <= sclk;
    seen_ff <= !rst && !power_down && (seen_ff || mod_clk != mq_ff);
    up_ff <= rst ? 2'h0 : (up_ff == 2'h3 ? up_ff : up_ff + 2'h1);
    mc_ff <= (mod_clk != mq_ff) ? 6'h00 : (mc_ff == 6'h3F ? mc_ff : mc_ff + 6'h01);
    fs_ff <= frame_sync ? 10'h000 : (fs_ff == 10'h3FF ? fs_ff : fs_ff + 10'h001);
    sr_ff <= (sclk && !sk_ff) ? 4'h0 : (sr_ff == 4'hF ? sr_ff : sr_ff + 4'h1);
  end
  // Pin relations; two sync flops give the fixed enable latency
  property p_err_lvl; error_n_out == 1'b0; endproperty
  a_err_lvl: assert property (p_err_lvl) else $error("error level");
  property p_oe; up_ff == 2'h3 |-> serial_out_oe == (!$past(chip_sel_n, 2) && $past(read_write, 2)); endproperty
  a_oe: assert property (p_oe) else $error("sout enable");
  property p_pd_clk; power_down [*6] |-> $stable(mod_clk); endproperty
  a_pd_clk: assert property (p_pd_clk) else $error("clock in pd");
  property p_clk_half; mod_clk != mq_ff && seen_ff |-> mc_ff == 6'h2F; endproperty
  a_clk_half: assert property (p_clk_half) else $error("clock half");
  property p_resync_src; $rose(modulator_resync) |-> fs_ff < 10'h320; endproperty
  a_resync_src: assert property (p_resync_src) else $error("resync cause");
  property p_flag_err; up_ff == 2'h3 && $rose(modulator_unstable_flag) |-> ##[1:8] error_n_oe; endproperty
  a_flag_err: assert property (p_flag_err) else $error("flag error");
  property p_err_hold; chip_sel_n [*6] |=> !$fell(error_n_oe); endproperty
  a_err_hold: assert property (p_err_hold) else $error("error drop");
  property p_sout_edge; $changed(serial_out) && !chip_sel_n |-> sclk && sr_ff < 4'h8; endproperty
  a_sout_edge: assert property (p_sout_edge) else $error("sout edge");
  c_resync: cover property ($rose(modulator_resync));
  c_err: cover property ($rose(error_n_oe));
  c_read: cover property ($rose(serial_out_oe));
endmodule
bind decimation_filter_control_port dfc_checker chk_u (
  .clk, .rst, .mod_clk, .modulator_resync, .modulator_unstable_flag, .frame_sync,
  .power_down, .chip_sel_n, .read_write, .sclk, .serial_out, .serial_out_oe,
  .error_n_out, .error_n_oe
);

// file: testbench/host_port_model.sv
/*
  Host processor model for the serial port.
  Assumes the caller runs on clk; the undriven output line pulls up.
*/
`timescale 1ns/100ps
module host_port_model (
  input wire logic clk, // system clock
  input wire logic serial_out, // port data out
  input wire logic serial_out_oe, // port drive enable
  output logic chip_sel_n, // chip select
  output logic read_write, // high read
  output logic sclk, // serial clock
  output logic serial_in // data to port
);
  logic line;
  // Output line with its pull-up
  assign line = serial_out_oe ? serial_out : 1'b1;
  // Idle: deselected, sclk parked low
  initial
  begin
    chip_sel_n = 1'b1;
    read_write = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end
  // One framed transfer; six-clock phases keep sclk edges apart
  task automatic xfer(input logic wr, input int n, input logic [23:0] wv,
                      output logic [23:0] rv);
    rv = 24'h000000;
    @(posedge clk);
    chip_sel_n <= 1'b0;
    read_write <= !wr;
    repeat (6) @(posedge clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk <= 1'b1;
      serial_in <= wv[i];
      repeat (6) @(posedge clk);
      rv = {rv[22:0], line};
      sclk <= 1'b0;
      repeat (6) @(posedge clk);
    end
    chip_sel_n <= 1'b1;
    read_write <= 1'b1;
    serial_in <= !serial_in; // Released line keeps no stale value
    @(posedge clk);
  endtask
endmodule

// file: testbench/decimation_filter_control_port_tb.sv
/*
  Self-checking bench for the filter control port.
  Assumes package, host model and checker compiled first.
*/
`timescale 1ns/100ps
module decimation_filter_control_port_tb;
  import dfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic frame_sync = 1'b0, power_down = 1'b0, source_select = 1'b0;
  logic hw_mode = 1'b0, register_choose = 1'b0;
  logic [2:0] dec = 3'h0;
  logic [2:0] flt = 3'h0;
  logic mod_clk, modulator_resync, chip_sel_n, read_write, sclk, serial_in;
  logic serial_out, serial_out_oe, error_n_out, error_n_oe, word_waiting;
  logic [23:0] rd;
  int mismatches = 0;
  int total_checks = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  decimation_filter_control_port dut_u (
    .clk, .rst, .mod_clk, .modulator_resync, .modulator_bitstream(1'b0),
    .test_bitstream(1'b1), .modulator_unstable_flag(flt[0]), .frame_sync,
    .power_down, .source_select, .hw_mode, .decim_sel0(dec[0]),
    .decim_sel1(dec[1]), .decim_sel2(dec[2]), .apply_offset_correction(1'b0),
    .offset_cal_request(1'b0), .accum1_fault(flt[1]), .accum2_fault(flt[2]),
    .chip_sel_n, .read_write, .sclk, .serial_in, .register_choose, .serial_out,
    .serial_out_oe, .error_n_out, .error_n_oe, .word_waiting
  );
  host_port_model host_u (
    .clk, .serial_out, .serial_out_oe, .chip_sel_n, .read_write, .sclk, .serial_in
  );
  task automatic check_eq(input logic [23:0] seen, input logic [23:0] exp, input string m);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s: %h not %h", $time, m, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic read_reg(input logic dsel, input int n);
    @(posedge clk);
    register_choose <= dsel;
    host_u.xfer(1'b0, n, 24'h000000, rd);
  endtask
  // Sync pulse; resync must follow within 800 clocks, two bit periods
  task automatic pulse_sync();
    int n;
    @(posedge clk);
    frame_sync <= 1'b1;
    repeat (8) @(posedge clk);
    frame_sync <= 1'b0;
    for (n = 0; n < 800 && modulator_resync !== 1'b1; n++) @(posedge clk);
    check_eq({23'h0, modulator_resync}, 24'h1, "resync");
  endtask
  // A missing word would stall the rest, so give up at once
  task automatic wait_word();
    int n;
    for (n = 0; n < 60000 && word_waiting !== 1'b1; n++) @(posedge clk);
    check_eq({23'h0, word_waiting}, 24'h1, "word wait");
    if (word_waiting !== 1'b1) stop_test();
  endtask
  task automatic t_reset();
    repeat (10) @(posedge clk);
    check_eq({21'h0, error_n_out, word_waiting, error_n_oe}, 24'h0, "reset");
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Written byte rules in software mode, pins in hardware mode
  task automatic t_config();
    host_u.xfer(1'b1, 8, 24'h000025, rd);
    check_eq(rd, 24'h0000FF, "float");
    read_reg(1'b0, 16);
    check_eq(rd, 24'h000025, "sw cfg");
    hw_mode <= 1'b1;
    dec <= 3'h6;
    source_select <= 1'b1;
    read_reg(1'b0, 16);
    check_eq(rd, 24'h000016, "hw cfg");
  endtask
  task automatic t_faults();
    int pos[3] = '{ST_MODULATOR_UNSTABLE_FLAG, ST_ACCUM1_FAULT, ST_ACCUM2_FAULT};
    for (int i = 0; i < 3; i++)
    begin
      flt[i] <= 1'b1;
      repeat (5) @(posedge clk);
      flt[i] <= 1'b0;
      repeat (10) @(posedge clk);
      check_eq({23'h0, error_n_oe}, 24'h1, "err pin");
      read_reg(1'b0, 16);
      check_eq(rd, 24'h008016 | (24'h1 << pos[i]), "fault");
      read_reg(1'b0, 16);
      check_eq({rd[15:0], 7'h0, error_n_oe}, 24'h001600, "cleared");
    end
    check_eq({23'h0, word_waiting}, 24'h0, "no sync");
  endtask
  // Test source all ones reads positive, modulator all zeros negative
  task automatic t_source();
    pulse_sync();
    wait_word();
    read_reg(1'b1, 24);
    check_eq({22'h0, rd[23], |rd}, 24'h1, "test src");
    repeat (8) @(posedge clk);
    check_eq({23'h0, word_waiting}, 24'h0, "taken");
    source_select <= 1'b0;
    pulse_sync();
    wait_word();
    read_reg(1'b1, 24);
    check_eq({23'h0, rd[23]}, 24'h1, "mod src");
  endtask
  task automatic t_pd();
    logic held;
    power_down <= 1'b1;
    repeat (20) @(posedge clk);
    held = mod_clk;
    repeat (144) @(posedge clk);
    check_eq({23'h0, mod_clk}, {23'h0, held}, "clk stop");
    read_reg(1'b0, 16);
    check_eq({16'h0, rd[7:0]}, 24'h000086, "pd status");
  endtask
  // Main sequence
  initial
  begin
    t_reset();
    t_config();
    t_faults();
    t_source();
    t_pd();
    stop_test();
  end
endmodule
